// ### design/vet_pkg.sv
// Constants, types and layouts shared by the video encoder timing block.
// Operation
// [RULE1] Progressive input takes three 10-bit component buses on every pixel clock.
// [RULE2] Progressive samples pass a 2x interpolator with sinc correction, no colour conversion.
// [RULE3] Shared pin high in timing reset mode holds horizontal and vertical counters cleared.
// [RULE4] The driver holds the timing reset pin high at least one pixel period.
// [RULE5] Rising pin edge in phase reset mode loads field 0 phase at next field.
// [RULE6] Genlock mode updates subcarrier frequency once per line from the serial stream.
// [RULE7] Genlock word has 67 bits, two clocks each; frequency in bits 0 to 21.
// [RULE8] Software writes zero to the subcarrier frequency registers in genlock mode.
// [RULE9] Subcarrier sync phase resets every four fields NTSC, every eight fields PAL.
// [RULE10] Subcarrier comes from a direct digital synthesizer with 32-bit phase accumulator.
// [RULE11] Avoid periodic phase reset with unstable sources; use phase reset mode unpulsed.
// [RULE12] Shared pin and standard pin both high after reset start in sleep.
// [RULE13] With power-up sleep disabled, sleep follows the software sleep bit.
// [RULE14] Square pixel needs its own clock, adapts line length, unavailable with 4x.
// [RULE15] Partial blanking encodes data on open blanking lines, else blanks them all.
// [RULE16] Full blanking spans 525-21, 262-284 or 624-22, 311-335.
// [RULE17] Open lines are 10-21, half 273-284 or 7-22, 319-335.
// [RULE18] Blank input disable at 0 honours external blank in slave modes 1 to 3.
// [RULE19] Level scaling touches component Y only: 700, 1000 or default 934/700 mV.
// [RULE20] 16-bit format needs separate syncs and is refused in slave mode 0.
// [RULE21] Outputs run at 2x oversampling or 4x through the internal PLL.
// [RULE22] Timing generator places sync, blanking, burst and equalisation pulses.
// [RULE23] Until pixel valid is set, input is ignored and timing outputs stay quiet; the code still toggles fieldOut at each field start.
`default_nettype none
package vet_pkg;
  localparam int          PIX_W            = 10;
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_FREQ         = 4'h1;
  localparam logic [3:0]  REG_STATUS       = 4'h2;
  localparam logic [3:0]  REG_GLFREQ       = 4'h3;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0044;
  localparam logic [31:0] CTRL_MASK        = 32'h0000_ffff;
  localparam logic [31:0] FREQ_RESET       = 32'h0000_0000;
  localparam logic [31:0] FIELD0_PHASE     = 32'h0000_0000;
  localparam logic [9:0]  NTSC_LINES       = 10'd525;
  localparam logic [9:0]  PAL_LINES        = 10'd625;
  localparam logic [9:0]  NTSC_FIELD2_LAST = 10'd262;
  localparam logic [9:0]  PAL_FIELD2_LAST  = 10'd312;
  localparam logic [2:0]  NTSC_SP_FIELDS   = 3'd3;
  localparam logic [2:0]  PAL_SP_FIELDS    = 3'd7;
  localparam logic [6:0]  GL_WORD_BITS     = 7'd67;
  localparam logic [6:0]  GL_FREQ_BITS     = 7'd22;
  localparam int          GL_BIT_CYC       = 2;
  localparam logic [9:0]  NTSC_EQ_LAST     = 10'd9;
  localparam logic [9:0]  PAL_EQ_LAST      = 10'd5;
  localparam logic [11:0] SYNC_END         = 12'd64;
  localparam logic [11:0] BURST_START      = 12'd76;
  localparam logic [11:0] BURST_END        = 12'd112;
  localparam logic [11:0] ACTIVE_START     = 12'd138;
  localparam logic [9:0]  Y_BLACK          = 10'h040;
  localparam logic [9:0]  C_ZERO           = 10'h200;
  localparam int          MV_FULL          = 1000;
  localparam int          MV_DEFAULT_NTSC  = 934;
  localparam int          MV_700           = 700;
  localparam int          MV_1000          = 1000;
  localparam int          SYS_CLK_MHZ      = 40;
  localparam int          PIN_MIN_NS       = 37;
  localparam int          PIN_MIN_CYC      = (PIN_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [1:0]  STRAP_CYC        = 2'd2;

  typedef enum logic [1:0] {
    GL_TIMING  = 2'b00,
    GL_SCPHASE = 2'b01,
    GL_STREAM  = 2'b10
  } vet_genlock_e;

  typedef enum logic [1:0] {
    LVL_DEFAULT = 2'b00,
    LVL_700     = 2'b01,
    LVL_1000    = 2'b10
  } vet_level_e;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_BITS = 1'b1
  } vet_rx_e;

  typedef struct packed {
    logic [15:0]  spare;
    logic         pixelValid;
    logic         master;
    logic [1:0]   timingMode;
    vet_level_e   levelSel;
    logic         fmt16;
    logic         fourX;
    logic         squarePixel;
    logic         powerUpSleepEn;
    logic         sleep;
    logic         blankInputDisable;
    logic         partialBlank;
    logic         periodicPhase;
    vet_genlock_e genlockMode;
  } vet_ctrl_s;

  typedef struct packed {
    logic [PIX_W-1:0] y;
    logic [PIX_W-1:0] cb;
    logic [PIX_W-1:0] cr;
  } vet_pix_s;
endpackage
`default_nettype wire

// ### design/vet_interp2x.sv
// Two-times interpolator with sinc correction for the progressive component path.
`default_nettype none
module vet_interp2x (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire vet_pkg::vet_pix_s inPix,
  output var  vet_pkg::vet_pix_s outA,
  output var  vet_pkg::vet_pix_s outB
);
  import vet_pkg::*;

  typedef struct packed {
    vet_pix_s p1;
    vet_pix_s p2;
    vet_pix_s a;
    vet_pix_s b;
  } vet_ip_s;

  vet_ip_s s;
  vet_ip_s next_s;

  function automatic logic [PIX_W-1:0] peak(input logic [PIX_W-1:0] c, input logic [PIX_W-1:0] l,
                                            input logic [PIX_W-1:0] r);
    logic signed [PIX_W+2:0] v;
    v = $signed({3'b000, c}) + ((($signed({3'b000, c}) <<< 1) - $signed({3'b000, l}) - $signed({3'b000, r})) >>> 3);
    if (v < 0) begin
      return '0;
    end else if (v > $signed({3'b000, {PIX_W{1'b1}}})) begin
      return {PIX_W{1'b1}};
    end
    return v[PIX_W-1:0];
  endfunction

  function automatic logic [PIX_W-1:0] mid(input logic [PIX_W-1:0] l, input logic [PIX_W-1:0] r);
    logic [PIX_W:0] t;
    t = {1'b0, l} + {1'b0, r};
    return t[PIX_W:1];
  endfunction

  always_comb begin
    next_s = s;
    next_s.p1 = inPix;
    next_s.p2 = s.p1;
    next_s.a = '{y: peak(s.p1.y, s.p2.y, inPix.y), cb: peak(s.p1.cb, s.p2.cb, inPix.cb),
                 cr: peak(s.p1.cr, s.p2.cr, inPix.cr)}; // [RULE2]
    next_s.b = '{y: mid(s.p1.y, inPix.y), cb: mid(s.p1.cb, inPix.cb), cr: mid(s.p1.cr, inPix.cr)}; // [RULE2]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign outA = s.a;
  assign outB = s.b;

  chk_interp_mid_sample: assert property (@(posedge sys_clk) disable iff (!resetn) // [RULE2]
    outB.y == 10'(({1'b0, $past(s.p1.y)} + {1'b0, $past(inPix.y)}) >> 1))
    else $error("Interpolated midpoint sample is wrong.");
endmodule
`default_nettype wire

// ### design/vet_timing_modes.sv
// Mode and timing control of the video encoder with its register port.
`default_nettype none
module vet_timing_modes #(
  parameter logic [11:0] NTSC_LINE_LEN = 12'd858,
  parameter logic [11:0] PAL_LINE_LEN  = 12'd864,
  parameter logic [11:0] NTSC_SQ_LEN   = 12'd780,
  parameter logic [11:0] PAL_SQ_LEN    = 12'd944
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [3:0]        busAddr,
  input  wire logic [31:0]       busWdata,
  input  wire logic              busWr,
  input  wire logic              busRd,
  output var  logic [31:0]       busRdata,
  input  wire logic              timingGenlockResetPin,
  input  wire logic              standardSelectPin,
  input  wire logic              blankInN,
  input  wire vet_pkg::vet_pix_s pixIn,
  output var  vet_pkg::vet_pix_s progA,
  output var  vet_pkg::vet_pix_s progB,
  output var  logic [9:0]        compY,
  output var  logic              syncOut,
  output var  logic              blankOut,
  output var  logic              burstGate,
  output var  logic              fieldOut,
  output var  logic [31:0]       scPhase,
  output var  logic              dacRate4x,
  output var  logic              sleepOut
);
  import vet_pkg::*;

  typedef struct packed {
    vet_ctrl_s   ctrl;
    logic [31:0] freq;
    logic [31:0] rdata;
    logic [2:0]  meta;
    logic [2:0]  sync;
    logic        pinPrev;
    logic [11:0] hCount;
    logic [9:0]  line;
    logic [2:0]  field;
    logic [31:0] phase;
    logic [31:0] activeFreq;
    logic        phasePending;
    vet_rx_e     glState;
    logic [6:0]  glBit;
    logic        glHalf;
    logic [21:0] glShift;
    logic [21:0] glFreq;
    logic        glDone;
    logic [1:0]  strapCnt;
    logic        strapSleep;
    vet_pix_s    pix;
    logic [9:0]  compY;
    logic        syncOut;
    logic        blankOut;
    logic        burstGate;
    logic        fieldOut;
    logic        fmtError;
    logic        sleep;
  } vet_state_s;

  vet_state_s s;
  vet_state_s next_s;

  function automatic logic fullVbi(input logic [9:0] ln, input logic pal);
    if (pal) begin
      return ln >= 10'd624 || ln <= 10'd22 || (ln >= 10'd311 && ln <= 10'd335); // [RULE16]
    end
    return ln >= 10'd525 || ln <= 10'd21 || (ln >= 10'd262 && ln <= 10'd284); // [RULE16]
  endfunction

  function automatic logic openVbi(input logic [9:0] ln, input logic pal, input logic secondHalf);
    if (pal) begin
      return (ln >= 10'd7 && ln <= 10'd22) || (ln >= 10'd319 && ln <= 10'd335); // [RULE17]
    end
    return (ln >= 10'd10 && ln <= 10'd21) || (ln == 10'd273 && secondHalf) ||
           (ln > 10'd273 && ln <= 10'd284); // [RULE17]
  endfunction

  function automatic logic [10:0] gainOf(input vet_level_e sel, input logic pal);
    int mv;
    mv = (sel == LVL_700 || (sel == LVL_DEFAULT && pal)) ? MV_700 :
         (sel == LVL_1000) ? MV_1000 : MV_DEFAULT_NTSC;
    return 11'((mv * 1024) / MV_FULL);
  endfunction

  logic        pal;
  logic        pinLvl;
  logic        sqActive;
  logic [11:0] lineLen;
  logic [9:0]  lastLine;
  logic [9:0]  field2Last;
  logic [2:0]  fieldLast;
  logic [2:0]  fieldNext;
  logic        lineEnd;
  logic        fieldStart;
  logic        counterHold;
  logic        phaseLoad;
  logic        sleepNow;
  logic        extBlank;
  logic        lineBlank;
  logic        eqLine;
  logic [11:0] halfLine;
  logic [20:0] yScaled;

  always_comb begin
    pal = s.sync[1];
    pinLvl = s.sync[0];
    sqActive = s.ctrl.squarePixel && !s.ctrl.fourX; // [RULE14]
    lineLen = sqActive ? (pal ? PAL_SQ_LEN : NTSC_SQ_LEN) : (pal ? PAL_LINE_LEN : NTSC_LINE_LEN); // [RULE14]
    halfLine = {1'b0, lineLen[11:1]};
    lastLine = pal ? PAL_LINES : NTSC_LINES;
    field2Last = pal ? PAL_FIELD2_LAST : NTSC_FIELD2_LAST;
    fieldLast = pal ? PAL_SP_FIELDS : NTSC_SP_FIELDS;
    fieldNext = (s.field >= fieldLast) ? 3'd0 : 3'(s.field + 3'd1);
    lineEnd = s.hCount >= 12'(lineLen - 12'd1);
    fieldStart = lineEnd && (s.line == lastLine || s.line == field2Last);
    counterHold = s.ctrl.genlockMode == GL_TIMING && pinLvl; // [RULE3]
    phaseLoad = fieldStart && (s.phasePending || (s.ctrl.periodicPhase && fieldNext == 3'd0)); // [RULE5] [RULE9]
    sleepNow = s.ctrl.sleep || (s.ctrl.powerUpSleepEn && s.strapSleep); // [RULE12] [RULE13]
    extBlank = !s.ctrl.blankInputDisable && !s.ctrl.master && s.ctrl.timingMode != 2'd0 && !s.sync[2]; // [RULE18]
    lineBlank = fullVbi(s.line, pal) && !(s.ctrl.partialBlank && openVbi(s.line, pal, s.hCount >= halfLine)); // [RULE15]
    eqLine = s.line <= (pal ? PAL_EQ_LAST : NTSC_EQ_LAST);
    yScaled = 21'(s.pix.y * gainOf(s.ctrl.levelSel, pal));
  end

  always_comb begin
    next_s = s;
    next_s.meta = {blankInN, standardSelectPin, timingGenlockResetPin};
    next_s.sync = s.meta;
    next_s.pinPrev = pinLvl;
    next_s.glDone = 1'b0;
    next_s.rdata = 32'h0;
    if (busRd) begin
      if (busAddr == REG_CTRL) begin
        next_s.rdata = s.ctrl;
      end else if (busAddr == REG_FREQ) begin
        next_s.rdata = s.freq;
      end else if (busAddr == REG_STATUS) begin
        next_s.rdata = {4'b0000, s.fmtError, s.sleep, sqActive, s.field, s.line, s.hCount};
      end else if (busAddr == REG_GLFREQ) begin
        next_s.rdata = {10'h0, s.glFreq};
      end
    end
    if (busWr) begin
      if (busAddr == REG_CTRL) begin
        next_s.ctrl = vet_ctrl_s'(busWdata & CTRL_MASK);
      end else if (busAddr == REG_FREQ) begin
        next_s.freq = busWdata;
      end
    end
    if (counterHold) begin
      next_s.hCount = 12'd0; // [RULE3]
      next_s.line = 10'd1; // [RULE3]
    end else if (lineEnd) begin
      next_s.hCount = 12'd0;
      next_s.line = (s.line >= lastLine) ? 10'd1 : 10'(s.line + 10'd1);
      next_s.activeFreq = (s.ctrl.genlockMode == GL_STREAM) ? {s.glFreq, 10'h000} : s.freq; // [RULE6]
    end else begin
      next_s.hCount = 12'(s.hCount + 12'd1);
    end
    if (s.ctrl.genlockMode == GL_SCPHASE && pinLvl && !s.pinPrev) begin
      next_s.phasePending = 1'b1; // [RULE5]
    end else if (fieldStart) begin
      next_s.phasePending = 1'b0;
    end
    if (fieldStart) begin
      next_s.field = s.phasePending ? 3'd0 : fieldNext; // [RULE5]
      next_s.fieldOut = !s.fieldOut;
    end
    if (phaseLoad) begin
      next_s.phase = FIELD0_PHASE; // [RULE5] [RULE9]
    end else if (!sleepNow) begin
      next_s.phase = 32'(s.phase + s.activeFreq); // [RULE10]
    end
    case (s.glState)
      RX_IDLE: begin
        if (s.ctrl.genlockMode == GL_STREAM && pinLvl && !s.pinPrev) begin
          next_s.glState = RX_BITS;
          next_s.glBit = 7'd0;
          next_s.glHalf = 1'b0;
        end
      end
      RX_BITS: begin
        next_s.glHalf = !s.glHalf; // [RULE7]
        if (s.glHalf) begin
          if (s.glBit < GL_FREQ_BITS) begin
            next_s.glShift[s.glBit[4:0]] = pinLvl; // [RULE7]
          end
          if (s.glBit == 7'(GL_WORD_BITS - 7'd1)) begin
            next_s.glFreq = s.glShift; // [RULE7]
            next_s.glDone = 1'b1;
            next_s.glState = RX_IDLE;
          end else begin
            next_s.glBit = 7'(s.glBit + 7'd1);
          end
        end
      end
      default: begin
        next_s.glState = RX_IDLE;
      end
    endcase
    if (s.strapCnt != 2'd3) begin
      next_s.strapCnt = 2'(s.strapCnt + 2'd1);
    end
    if (s.strapCnt == STRAP_CYC) begin
      next_s.strapSleep = pinLvl && pal; // [RULE12]
    end
    next_s.sleep = sleepNow;
    next_s.fmtError = s.ctrl.fmt16 && s.ctrl.timingMode == 2'd0; // [RULE20]
    if (!s.ctrl.pixelValid) begin
      next_s.pix = '{y: Y_BLACK, cb: C_ZERO, cr: C_ZERO}; // [RULE23]
    end else begin
      next_s.pix = pixIn; // [RULE1]
    end
    next_s.compY = (|yScaled[20:20]) ? 10'h3ff : yScaled[19:10]; // [RULE19]
    next_s.blankOut = s.ctrl.pixelValid && (lineBlank || extBlank || s.hCount < ACTIVE_START); // [RULE22] [RULE23]
    if (!s.ctrl.pixelValid) begin
      next_s.syncOut = 1'b0; // [RULE23]
      next_s.burstGate = 1'b0;
    end else if (eqLine) begin
      next_s.syncOut = s.hCount < {1'b0, SYNC_END[11:1]} ||
                       (s.hCount >= halfLine && s.hCount < 12'(halfLine + {1'b0, SYNC_END[11:1]})); // [RULE22]
      next_s.burstGate = 1'b0; // [RULE22]
    end else begin
      next_s.syncOut = s.hCount < SYNC_END; // [RULE22]
      next_s.burstGate = !fullVbi(s.line, pal) && s.hCount >= BURST_START && s.hCount < BURST_END; // [RULE22]
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.ctrl <= vet_ctrl_s'(CTRL_RESET);
      s.freq <= FREQ_RESET;
      s.line <= 10'd1;
    end else begin
      s <= next_s;
    end
  end

  vet_interp2x u_interp (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .inPix   (s.pix),
    .outA    (progA),
    .outB    (progB)
  );

  assign busRdata = s.rdata;
  assign compY = s.compY;
  assign syncOut = s.syncOut;
  assign blankOut = s.blankOut;
  assign burstGate = s.burstGate;
  assign fieldOut = s.fieldOut;
  assign scPhase = s.phase;
  assign dacRate4x = s.ctrl.fourX; // [RULE21]
  assign sleepOut = s.sleep;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence pinHeld;
    s.ctrl.genlockMode == GL_TIMING && pinLvl [*2];
  endsequence

  sequence wordEnd;
    s.glState == RX_BITS && s.glHalf && s.glBit == 7'd66;
  endsequence

  chk_counter_hold_clear: assert property (pinHeld |=> s.hCount == 12'd0 && s.line == 10'd1) // [RULE3]
    else $error("Counters not held clear under timing reset.");
  chk_phase_field_load: assert property (fieldStart && s.phasePending |=> s.phase == FIELD0_PHASE && s.field == 3'd0) // [RULE5]
    else $error("Phase reset not applied at field start.");
  chk_dds_step_add: assert property (!phaseLoad && !sleepNow |=> s.phase == $past(s.phase) + $past(s.activeFreq)) // [RULE10]
    else $error("Phase accumulator did not advance.");
  chk_word_freq_load: assert property (wordEnd |=> s.glDone && s.glFreq == $past(s.glShift)) // [RULE7]
    else $error("Genlock word end did not load frequency.");
  chk_line_freq_take: assert property (lineEnd && !counterHold && s.ctrl.genlockMode == GL_STREAM
    |=> s.activeFreq == {$past(s.glFreq), 10'h000}) // [RULE6]
    else $error("Line start did not take genlock frequency.");
  chk_periodic_field_reset: assert property (fieldStart && s.ctrl.periodicPhase && s.field == fieldLast |=> s.phase == FIELD0_PHASE) // [RULE9]
    else $error("Periodic phase reset missing.");
  chk_strap_sleep_start: assert property (s.strapCnt == 2'd2 && pinLvl && pal && s.ctrl.powerUpSleepEn
    ##1 s.ctrl.powerUpSleepEn |=> s.sleep) // [RULE12]
    else $error("Strapped sleep not entered.");
  chk_sleep_bit_follow: assert property (!s.ctrl.powerUpSleepEn |=> s.sleep == $past(s.ctrl.sleep)) // [RULE13]
    else $error("Sleep does not follow the sleep bit.");
  chk_quiet_invalid_pix: assert property (!s.ctrl.pixelValid ##1 !s.ctrl.pixelValid |-> !syncOut && !burstGate && !blankOut) // [RULE23]
    else $error("Timing outputs active before pixel valid.");
  chk_full_vbi_blank: assert property (s.ctrl.pixelValid && fullVbi(s.line, pal) && !s.ctrl.partialBlank |=> blankOut) // [RULE15]
    else $error("Blanking line not blanked.");
  chk_fmt16_mode0_flag: assert property (s.ctrl.fmt16 && s.ctrl.timingMode == 2'd0 |=> s.fmtError) // [RULE20]
    else $error("16-bit format in mode 0 not flagged.");
endmodule
`default_nettype wire

// ### test/vet_decoder_model.sv
// Pixel source and genlock stream driver standing in for the upstream decoder.
`default_nettype none
module vet_decoder_model
  import vet_pkg::*;
(
  input  wire logic     sys_clk,
  output var  vet_pix_s pixOut,
  output var  logic     rtcOut
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam vet_pix_s PIX_FIXED = '{y: 10'h2c5, cb: 10'h13a, cr: 10'h1e7};

  initial begin
    pixOut = '0;
    rtcOut = 1'b0;
  end

  // The same fixed 10-bit triple is driven on every rising pixel clock edge.
  always @(posedge sys_clk) begin
    pixOut <= PIX_FIXED;
  end

  // Start bit, then the word LSB first with each bit two clocks long.
  task automatic send_word(input logic [21:0] freq);
    logic [66:0] word;
    word = {45'h0, freq};
    repeat (GL_BIT_CYC) @(posedge sys_clk) rtcOut <= 1'b1;
    for (int i = 0; i < 67; i++) begin
      repeat (GL_BIT_CYC) @(posedge sys_clk) rtcOut <= word[i];
    end
    @(posedge sys_clk) rtcOut <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/video_encoder_timing_modes_bench.sv
// Self-checking bench for the video encoder mode and timing block.
`default_nettype none
module video_encoder_timing_modes_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import vet_pkg::*;
  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } row_s;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [2:0]  exp;
  } mode_s;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  busAddr = '0;
  logic [31:0] busWdata = '0;
  logic        busWr = 1'b0;
  logic        busRd = 1'b0;
  logic [31:0] busRdata;
  logic        benchPin = 1'b1;
  logic        standardSelectPin = 1'b1;
  logic        blankInN = 1'b1;
  logic        rtcOut;
  vet_pix_s    pixIn, progA, progB;
  logic [9:0]  compY;
  logic        syncOut, blankOut, burstGate, fieldOut, dacRate4x, sleepOut;
  logic [31:0] scPhase, rd, ph0;
  int          err_total = 0;
  int          tests_run = 0;
  row_s        rows [3];
  mode_s       modes [5];
  logic [21:0] glf;
  logic        fo;
  logic [31:0] ncnt;

  always #12.5 sys_clk = ~sys_clk;

  vet_decoder_model u_vet_decoder_model (.sys_clk(sys_clk), .pixOut(pixIn), .rtcOut(rtcOut));

  vet_timing_modes #(.NTSC_LINE_LEN(12'd100), .PAL_LINE_LEN(12'd100)) u_vet_timing_modes (
    .sys_clk(sys_clk), .resetn(resetn), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata), .timingGenlockResetPin(benchPin | rtcOut),
    .standardSelectPin(standardSelectPin), .blankInN(blankInN), .pixIn(pixIn), .progA(progA),
    .progB(progB), .compY(compY), .syncOut(syncOut), .blankOut(blankOut), .burstGate(burstGate),
    .fieldOut(fieldOut), .scPhase(scPhase), .dacRate4x(dacRate4x), .sleepOut(sleepOut));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    busWr <= 1'b1;
    busAddr <= a;
    busWdata <= d;
    @(posedge sys_clk);
    busWr <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge sys_clk);
    busRd <= 1'b0;
    @(negedge sys_clk);
    d = busRdata;
  endtask

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(90000 * 25);
    err_total++;
    $display("ERROR watchdog expected finish seen hang");
    test_done();
  end

  initial begin
    rows[0] = '{REG_FREQ, 32'h1234_5678, 32'h1234_5678};
    rows[1] = '{4'h9, 32'hffff_ffff, 32'h0000_0000};
    rows[2] = '{REG_CTRL, 32'hffff_0000, 32'h0000_0000};
    modes[0] = '{32'h0000_8100, 3'b100};
    modes[1] = '{32'h0000_8080, 3'b010};
    modes[2] = '{32'h0000_8180, 3'b100};
    modes[3] = '{32'h0000_8200, 3'b001};
    modes[4] = '{32'h0000_a200, 3'b000};
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("sleepOut", {31'h0, sleepOut}, 32'h1);
    chk("syncOut", {31'h0, syncOut}, 32'h0);
    chk("blankOut", {31'h0, blankOut}, 32'h0);
    chk("burstGate", {31'h0, burstGate}, 32'h0);
    chk("progB", {2'h0, progB}, {2'h0, Y_BLACK, C_ZERO, C_ZERO});
    rdr(REG_CTRL, rd);
    chk("ctrl reset", rd, CTRL_RESET);
    rdr(REG_STATUS, rd);
    chk("counters held", {10'h0, rd[21:0]}, {20'h0, 12'h000} | 32'h0000_1000);
    benchPin <= 1'b0;
    standardSelectPin <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rdr(REG_STATUS, rd);
    chk("counting", {31'h0, rd[11:0] != 12'h0}, 32'h1);
    $display("Test reset done");
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      rdr(rows[i].addr, rd);
      chk("row readback", rd, rows[i].rexp);
    end
    chk("sleep strap off", {31'h0, sleepOut}, 32'h0);
    wr(REG_CTRL, 32'h0000_0020);
    repeat (3) @(posedge sys_clk);
    chk("sleep bit", {31'h0, sleepOut}, 32'h1);
    foreach (modes[i]) begin
      wr(REG_CTRL, modes[i].ctrl);
      repeat (3) @(posedge sys_clk);
      rdr(REG_STATUS, rd);
      chk("mode flags", {29'h0, dacRate4x, rd[25], rd[27]}, {29'h0, modes[i].exp});
    end
    $display("Test registers and modes done");
    wr(REG_CTRL, 32'h0000_8000);
    repeat (8) @(posedge sys_clk);
    chk("progA", {2'h0, progA}, {2'h0, u_vet_decoder_model.PIX_FIXED});
    chk("progB", {2'h0, progB}, {2'h0, u_vet_decoder_model.PIX_FIXED});
    chk("compY default", {22'h0, compY}, 32'h0000_0295);
    chk("blank on", {31'h0, blankOut}, 32'h1);
    @(negedge sys_clk);
    while (syncOut !== 1'b0) @(negedge sys_clk);
    while (syncOut !== 1'b1) @(negedge sys_clk);
    ncnt = '0;
    repeat (100) @(negedge sys_clk) ncnt = ncnt + {31'h0, syncOut};
    chk("sync width", ncnt, 32'd64);
    wr(REG_CTRL, 32'h0000_8400);
    repeat (4) @(posedge sys_clk);
    chk("compY 700", {22'h0, compY}, 32'h0000_01ef);
    $display("Test pixel path done");
    glf = 22'h2a5c3;
    wr(REG_FREQ, 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_8002);
    u_vet_decoder_model.send_word(glf);
    repeat (4) @(posedge sys_clk);
    rdr(REG_GLFREQ, rd);
    chk("genlock freq", rd, {10'h0, glf});
    repeat (250) @(posedge sys_clk);
    @(negedge sys_clk) ph0 = scPhase;
    @(negedge sys_clk) chk("dds step", scPhase - ph0, {glf, 10'h0});
    $display("Test genlock done");
    wr(REG_FREQ, 32'h0001_0000);
    wr(REG_CTRL, 32'h0000_8001);
    @(posedge sys_clk) benchPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    benchPin <= 1'b0;
    fo = fieldOut;
    for (int n = 0; n < 40000 && fieldOut === fo; n++) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("field toggled", {31'h0, fieldOut !== fo}, 32'h1);
    chk("phase at field", {31'h0, scPhase < 32'h0010_0000}, 32'h1);
    rdr(REG_STATUS, rd);
    chk("field index", {29'h0, rd[24:22]}, 32'h0);
    $display("Test phase reset done");
    test_done();
  end
endmodule
`default_nettype wire
